// ### tacl_pkg.sv
// What this block does
// - write to a general register in its write state suppresses that compare match
// - counter write beats wrap step, overflow flag still sets
// - general register read during capture returns the pre-capture value
// - capture clear plus increment: clear wins, capture loads pre-clear count
// - capture during general register write: capture stored, write dropped
// - compare clear happens on the last matching state, giving clock over N+1
// - capture into buffered register beats a buffer register write
// - synchronized counter write loads all 16 bits into every synchronized counter
// - leaving complementary mode returns pair to normal; run bits stop counters
// - capture clearing the counter at all-ones raises no overflow
// - no input capture on a channel in PWM mode
// - simultaneous compare A and B in PWM mode suppresses the match
// - status flags clear only by writing zero after reading one
// - counter clear during counter write wins, write ignored
// - overflow flag sets on wrap all-ones to zero or zero to all-ones
package tacl_pkg;
  localparam int NCH = 5;
  localparam int CW = 16;
  localparam int PRE_W = 3;
  // register byte offsets
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STAT = 5'h04;
  localparam logic [4:0] OFF_CNT = 5'h08;
  localparam logic [4:0] OFF_GRA = 5'h0C;
  localparam logic [4:0] OFF_GRB = 5'h10;
  localparam logic [4:0] OFF_BRA = 5'h14;
  localparam logic [7:0] GLB_RUN = 8'hA0;
  localparam logic [7:0] GLB_SYNC = 8'hA4;
  localparam logic [7:0] GLB_FUNC = 8'hA8;
  // reset values
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] RST_GR = 16'hFFFF;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [4:0] RST_RUN = 5'h00;
  localparam logic [4:0] RST_SYNC = 5'h00;
  localparam logic [1:0] RST_CMB = 2'h0;
  // channel whose counter runs down in complementary mode
  localparam int CH_DOWN = 4;
  // status bit positions
  localparam int ST_FA = 0;
  localparam int ST_FB = 1;
  localparam int ST_OVF = 2;
  // combination mode codes
  localparam logic [1:0] CMB_NORMAL = 2'h0;
  localparam logic [1:0] CMB_COMPL = 2'h2;
  localparam logic [1:0] CMB_RSYNC = 2'h3;
  // counter clear sources
  typedef enum logic [1:0] {
    CLR_NONE = 2'h0,
    CLR_A = 2'h1,
    CLR_B = 2'h2,
    CLR_SYNC = 2'h3
  } tacl_clr_t;
  // channel control register, bit 7 down to bit 0
  typedef struct packed {
    logic buf_en;
    logic pulse_width_mode_bit;
    logic capture_select_b;
    logic capture_select_a;
    logic [1:0] cks;
    tacl_clr_t clr_src;
  } tacl_ctl_t;
  // per-channel access strobes from the bus side
  typedef struct packed {
    logic cnt;
    logic gra;
    logic grb;
    logic bra;
    logic stat_rd;
    logic stat_wr;
  } tacl_wr_t;
endpackage : tacl_pkg

// ### tacl_chan.sv
`timescale 1ns/1ps
module tacl_chan
  import tacl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire tacl_ctl_t ctl,
  input wire logic down,
  // timing events
  input wire logic tick,
  input wire logic ext_clr,
  input wire logic cap_a_ev,
  input wire logic cap_b_ev,
  // bus writes, active in the write's third state; the status read strobe is active in the read's address phase
  input wire tacl_wr_t wr,
  input wire logic [CW-1:0] cnt_wval,
  input wire logic [CW-1:0] wval,
  // state
  output logic [CW-1:0] timer_count,
  output logic [CW-1:0] gra,
  output logic [CW-1:0] grb,
  output logic [CW-1:0] buffer_reg,
  output logic [2:0] flags,
  output logic clr_req,
  output logic cmp_a,
  output logic cmp_b
);
  logic [CW-1:0] cnt_nxt, gra_nxt, grb_nxt, br_nxt;
  logic [2:0] flags_nxt, seen_r, seen_nxt, fset, fclr;
  logic cap_a, cap_b, hit_a, hit_b, pwm_both, do_clr, wrap;

  // event qualification and contention
  always_comb begin
    cap_a = cap_a_ev & ctl.capture_select_a & ~ctl.pulse_width_mode_bit;
    cap_b = cap_b_ev & ctl.capture_select_b & ~ctl.pulse_width_mode_bit;
    // match is seen on the tick that leaves the matching count
    hit_a = tick & (timer_count == gra);
    hit_b = tick & (timer_count == grb);
    pwm_both = ctl.pulse_width_mode_bit & hit_a & hit_b;
    cmp_a = hit_a & (ctl.pulse_width_mode_bit | ~ctl.capture_select_a) & ~wr.gra & ~pwm_both;
    cmp_b = hit_b & (ctl.pulse_width_mode_bit | ~ctl.capture_select_b) & ~wr.grb & ~pwm_both;
    clr_req = ((ctl.clr_src == CLR_A) & (cmp_a | cap_a)) | ((ctl.clr_src == CLR_B) & (cmp_b | cap_b));
    do_clr = clr_req | ((ctl.clr_src == CLR_SYNC) & ext_clr);
    wrap = tick & (down ? (timer_count == RST_CNT) : (timer_count == RST_GR));
  end

  // next register values; clear beats write beats count step
  always_comb begin
    cnt_nxt = timer_count;
    if (do_clr) begin
      cnt_nxt = RST_CNT;
    end else if (wr.cnt) begin
      cnt_nxt = cnt_wval;
    end else if (tick) begin
      cnt_nxt = down ? timer_count - 16'h0001 : timer_count + 16'h0001;
    end
    // capture takes the count before any clear and beats the cpu write
    gra_nxt = cap_a ? timer_count : (wr.gra ? wval : gra);
    grb_nxt = cap_b ? timer_count : (wr.grb ? wval : grb);
    br_nxt = (cap_a & ctl.buf_en) ? gra : (wr.bra ? wval : buffer_reg);
    // an overflow swallowed by a clear is not an overflow
    fset = {wrap & ~do_clr, cmp_b | cap_b, cmp_a | cap_a};
    fclr = wr.stat_wr ? (seen_r & ~wval[2:0]) : 3'h0;
    flags_nxt = fset | (flags & ~fclr);
    seen_nxt = ((wr.stat_rd ? flags : 3'h0) | seen_r) & ~fclr;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_count <= RST_CNT;
      gra <= RST_GR;
      grb <= RST_GR;
      buffer_reg <= RST_GR;
      flags <= 3'h0;
      seen_r <= 3'h0;
    end else begin
      timer_count <= cnt_nxt;
      gra <= gra_nxt;
      grb <= grb_nxt;
      buffer_reg <= br_nxt;
      flags <= flags_nxt;
      seen_r <= seen_nxt;
    end
  end

  a_wr_beats_cmp: assert property (@(posedge clk) disable iff (rst) (wr.gra & hit_a) |-> !cmp_a)
    else $error("compare match not suppressed by register write");
  a_ovf_on_write: assert property (@(posedge clk) disable iff (rst)
    (wr.cnt & wrap & ~do_clr) |=> (timer_count == $past(cnt_wval)) && flags[ST_OVF])
    else $error("write during wrap lost value or flag");
  a_cap_clear_load: assert property (@(posedge clk) disable iff (rst)
    (cap_a & ctl.clr_src == CLR_A) |=> (timer_count == RST_CNT) && (gra == $past(timer_count)))
    else $error("capture clear did not load pre-clear count");
  a_cap_beats_wr: assert property (@(posedge clk) disable iff (rst)
    (cap_b & wr.grb) |=> grb == $past(timer_count))
    else $error("register write overrode capture");
  a_cmp_clear_last: assert property (@(posedge clk) disable iff (rst)
    (cmp_b & ctl.clr_src == CLR_B) |=> timer_count == RST_CNT)
    else $error("compare clear missed");
  a_buf_cap_wins: assert property (@(posedge clk) disable iff (rst)
    (cap_a & ctl.buf_en & wr.bra) |=> buffer_reg == $past(gra))
    else $error("buffer write overrode capture transfer");
  a_no_ovf_capclr: assert property (@(posedge clk) disable iff (rst)
    (do_clr & ~flags[ST_OVF] & timer_count == RST_GR) |=> !flags[ST_OVF])
    else $error("overflow raised on clear at all-ones");
  a_pwm_gr_hold: assert property (@(posedge clk) disable iff (rst)
    (ctl.pulse_width_mode_bit & ~wr.gra & cap_a_ev) |=> gra == $past(gra))
    else $error("capture taken in pwm mode");
  a_pwm_both_mask: assert property (@(posedge clk) disable iff (rst)
    (ctl.pulse_width_mode_bit & hit_a & hit_b) |-> !cmp_a && !cmp_b)
    else $error("simultaneous pwm matches not suppressed");
  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    (flags[ST_FA] & ~seen_r[ST_FA]) |=> flags[ST_FA])
    else $error("flag cleared without prior read");
  a_clr_beats_wr: assert property (@(posedge clk) disable iff (rst) (do_clr & wr.cnt) |=> timer_count == RST_CNT)
    else $error("write overrode counter clear");
  a_wrap_sets_ovf: assert property (@(posedge clk) disable iff (rst) (wrap & ~do_clr) |=> flags[ST_OVF])
    else $error("wrap did not set overflow");
  c_overflow: cover property (@(posedge clk) disable iff (rst) wrap & ~do_clr);
  c_cap_during_wr: cover property (@(posedge clk) disable iff (rst) cap_a & wr.gra);
  c_cmp_clear: cover property (@(posedge clk) disable iff (rst) cmp_a & ctl.clr_src == CLR_A);
endmodule : tacl_chan

// ### tacl_top.sv
`timescale 1ns/1ps
module tacl_top
  import tacl_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // capture pins, asynchronous
  input wire logic [NCH-1:0] CAP_A_PIN,
  input wire logic [NCH-1:0] CAP_B_PIN,
  // compare match pulses
  output logic [NCH-1:0] MATCH_A,
  output logic [NCH-1:0] MATCH_B
);
  // bus data-phase state
  logic dph_wr_r, dph_wr_nxt;
  logic [7:0] dph_addr_r, dph_addr_nxt;
  logic [1:0] dph_be_r, dph_be_nxt;
  logic [31:0] rdata_nxt;
  logic a_ok;
  logic [1:0] be_a;

  // software registers
  tacl_ctl_t ctl_r [NCH];
  tacl_ctl_t ctl_nxt [NCH];
  logic [NCH-1:0] run_r, run_nxt;
  logic [NCH-1:0] sync_r, sync_nxt;
  logic [1:0] cmb_r, cmb_nxt;

  // prescaler and pin synchronisers
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic [3:0] pre_en;
  logic [NCH-1:0] ca_s1, ca_s2, ca_s3;
  logic [NCH-1:0] cb_s1, cb_s2, cb_s3;

  // channel wiring
  logic [CW-1:0] cnt_v [NCH];
  logic [CW-1:0] gra_v [NCH];
  logic [CW-1:0] grb_v [NCH];
  logic [CW-1:0] br_v [NCH];
  logic [2:0] flg_v [NCH];
  logic [NCH-1:0] clr_v, cmpa_v, cmpb_v, tick_v, down_v;
  tacl_wr_t wr_v [NCH];
  logic [CW-1:0] cnt_wval;
  logic sync_clr;

  // data-phase decode
  logic [2:0] w_ch;
  logic [4:0] w_off;
  logic w_glb;
  logic cnt_wr;
  logic [CW-1:0] merged;

  // address phase taken when selected, active and the bus is ready
  always_comb begin
    a_ok = HSEL & HTRANS[1] & HREADY;
    // byte lanes of a 16-bit register from size and address
    if (HSIZE == 3'h0) begin
      be_a = {HADDR[1:0] == 2'h1, HADDR[1:0] == 2'h0};
    end else begin
      be_a = {~HADDR[1], ~HADDR[1]};
    end
    dph_wr_nxt = a_ok & HWRITE;
    dph_addr_nxt = a_ok ? HADDR[7:0] : dph_addr_r;
    dph_be_nxt = a_ok ? be_a : dph_be_r;
  end

  // read mux sampled at the address phase, so a capture landing in
  // the data phase cannot change the word already on its way
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [2:0] ch;
    logic [31:0] v;
    ch = a[7:5];
    v = 32'h0000_0000;
    if (a == GLB_RUN) begin
      v = {27'h0, run_r};
    end else if (a == GLB_SYNC) begin
      v = {27'h0, sync_r};
    end else if (a == GLB_FUNC) begin
      v = {30'h0, cmb_r};
    end else if (32'(ch) < NCH) begin
      unique case (a[4:0])
        OFF_CTRL: v = {24'h0, ctl_r[ch]};
        OFF_STAT: v = {29'h0, flg_v[ch]};
        OFF_CNT: v = {16'h0, cnt_v[ch]};
        OFF_GRA: v = {16'h0, gra_v[ch]};
        OFF_GRB: v = {16'h0, grb_v[ch]};
        OFF_BRA: v = {16'h0, br_v[ch]};
        default: v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction : rd_word

  always_comb begin
    rdata_nxt = HRDATA;
    if (a_ok & ~HWRITE) begin
      rdata_nxt = rd_word(HADDR[7:0]);
    end
  end

  // write decode in the data phase, which is the write's third state
  always_comb begin
    w_ch = dph_addr_r[7:5];
    w_off = dph_addr_r[4:0];
    w_glb = (w_ch == 3'h5);
    cnt_wr = dph_wr_r & ~w_glb & (32'(w_ch) < NCH) & (w_off == OFF_CNT);
    // partial writes merge into the addressed counter first
    merged = cnt_v[0];
    for (int i = 0; i < NCH; i++) begin
      if (32'(w_ch) == i) begin
        merged = cnt_v[i];
      end
    end
    cnt_wval = {dph_be_r[1] ? HWDATA[15:8] : merged[15:8], dph_be_r[0] ? HWDATA[7:0] : merged[7:0]};
  end

  // per-channel strobes; a sync member's preset goes to every member
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      wr_v[i] = '0;
      wr_v[i].stat_rd = a_ok & ~HWRITE & (32'(HADDR[7:5]) == i) & (HADDR[4:0] == OFF_STAT);
      if (dph_wr_r & (32'(w_ch) == i)) begin
        wr_v[i].gra = (w_off == OFF_GRA);
        wr_v[i].grb = (w_off == OFF_GRB);
        wr_v[i].bra = (w_off == OFF_BRA);
        wr_v[i].stat_wr = (w_off == OFF_STAT);
      end
      if (cnt_wr) begin
        if (sync_r[w_ch]) begin
          wr_v[i].cnt = sync_r[i];
        end else begin
          wr_v[i].cnt = (32'(w_ch) == i);
        end
      end
    end
  end

  // software register writes
  always_comb begin
    run_nxt = run_r;
    sync_nxt = sync_r;
    cmb_nxt = cmb_r;
    for (int i = 0; i < NCH; i++) begin
      ctl_nxt[i] = ctl_r[i];
      if (dph_wr_r & dph_be_r[0] & (32'(w_ch) == i) & (w_off == OFF_CTRL)) begin
        ctl_nxt[i] = tacl_ctl_t'(HWDATA[7:0]);
      end
    end
    if (dph_wr_r & dph_be_r[0]) begin
      if (dph_addr_r == GLB_RUN) begin
        run_nxt = HWDATA[NCH-1:0];
      end
      if (dph_addr_r == GLB_SYNC) begin
        sync_nxt = HWDATA[NCH-1:0];
      end
      if (dph_addr_r == GLB_FUNC) begin
        cmb_nxt = HWDATA[1:0];
      end
    end
  end

  // prescaler enables: every cycle, every 2nd, 4th and 8th
  always_comb begin
    pre_nxt = pre_r + 3'h1;
    pre_en[0] = 1'b1;
    pre_en[1] = pre_r[0];
    pre_en[2] = &pre_r[1:0];
    pre_en[3] = &pre_r[2:0];
  end

  // synchronized clear: any member's own clear reaches the others
  always_comb begin
    sync_clr = |(clr_v & sync_r);
    for (int i = 0; i < NCH; i++) begin
      tick_v[i] = run_r[i] & pre_en[ctl_r[i].cks];
      // only the second of the complementary pair counts down, and
      // only while the mode is really selected
      down_v[i] = (i == CH_DOWN) & (cmb_r == CMB_COMPL);
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      dph_wr_r <= 1'b0;
      dph_addr_r <= 8'h00;
      dph_be_r <= 2'h0;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      run_r <= RST_RUN;
      sync_r <= RST_SYNC;
      cmb_r <= RST_CMB;
      pre_r <= '0;
      MATCH_A <= '0;
      MATCH_B <= '0;
    end else begin
      dph_wr_r <= dph_wr_nxt;
      dph_addr_r <= dph_addr_nxt;
      dph_be_r <= dph_be_nxt;
      HRDATA <= rdata_nxt;
      // zero wait states, every access answers okay
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      run_r <= run_nxt;
      sync_r <= sync_nxt;
      cmb_r <= cmb_nxt;
      pre_r <= pre_nxt;
      MATCH_A <= cmpa_v;
      MATCH_B <= cmpb_v;
    end
  end

  // pins are asynchronous: two flops, then the third only for edges
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ca_s1 <= '0;
      ca_s2 <= '0;
      ca_s3 <= '0;
      cb_s1 <= '0;
      cb_s2 <= '0;
      cb_s3 <= '0;
    end else begin
      ca_s1 <= CAP_A_PIN;
      ca_s2 <= ca_s1;
      ca_s3 <= ca_s2;
      cb_s1 <= CAP_B_PIN;
      cb_s2 <= cb_s1;
      cb_s3 <= cb_s2;
    end
  end

  // channels, each with its own control register
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
        ctl_r[g] <= tacl_ctl_t'(RST_CTRL);
      end else begin
        ctl_r[g] <= ctl_nxt[g];
      end
    end

    tacl_chan u_chan (
      .clk(SYS_CLK),
      .rst(RST),
      .ctl(ctl_r[g]),
      .down(down_v[g]),
      .tick(tick_v[g]),
      .ext_clr(sync_clr & sync_r[g]),
      .cap_a_ev(ca_s2[g] & ~ca_s3[g]),
      .cap_b_ev(cb_s2[g] & ~cb_s3[g]),
      .wr(wr_v[g]),
      .cnt_wval(cnt_wval),
      .wval(HWDATA[CW-1:0]),
      .timer_count(cnt_v[g]),
      .gra(gra_v[g]),
      .grb(grb_v[g]),
      .buffer_reg(br_v[g]),
      .flags(flg_v[g]),
      .clr_req(clr_v[g]),
      .cmp_a(cmpa_v[g]),
      .cmp_b(cmpb_v[g])
    );
  end

  a_sync_preset_all: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cnt_wr & sync_r[w_ch] & ~sync_clr) |=> (cnt_v[0] == $past(cnt_wval)) || !$past(sync_r[0]))
    else $error("synchronized preset missed a member");
  a_read_word_held: assert property (@(posedge SYS_CLK) disable iff (RST)
    (a_ok & ~HWRITE) |=> ##1 (HRDATA == $past(HRDATA)) || $past(a_ok & ~HWRITE))
    else $error("read data changed inside its data phase");
  c_sync_write: cover property (@(posedge SYS_CLK) disable iff (RST) cnt_wr & sync_r[w_ch]);
  c_compl_mode: cover property (@(posedge SYS_CLK) disable iff (RST) cmb_r == CMB_COMPL && run_r[CH_DOWN]);
endmodule : tacl_top

// ### tacl_cpu_model.sv
`timescale 1ns/1ps
module tacl_cpu_model
  import tacl_pkg::*;
(
  // bus clock
  input wire logic clk,
  // slave answer
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // master request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end
  // one single word transfer, every change just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
    // released data must not look like a held value
    hwdata <= ~d;
  endtask : xfer
  // register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  // register read
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h00000000, q);
  endtask : rd
endmodule : tacl_cpu_model

// ### tacl_tb.sv
`timescale 1ns/1ps
module tacl_tb
  import tacl_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [NCH-1:0] cap_a_pin = '0;
  logic [NCH-1:0] cap_b_pin = '0;
  logic hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [NCH-1:0] match_a, match_b;
  int errors = 0;
  int tests_run = 0;

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  tacl_top DUT (.SYS_CLK(sys_clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .CAP_A_PIN(cap_a_pin), .CAP_B_PIN(cap_b_pin),
    .MATCH_A(match_a), .MATCH_B(match_b));

  tacl_cpu_model cpu (.clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [7:0] ra(input int ch, input logic [4:0] off);
    return {3'(ch), off};
  endfunction : ra

  // pin held long enough for the two-flop synchroniser, then settle
  task automatic pulse(input int ch, input logic b);
    @(posedge sys_clk);
    if (b) cap_b_pin[ch] <= 1'b1;
    else cap_a_pin[ch] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cap_a_pin <= '0;
    cap_b_pin <= '0;
    repeat (6) @(posedge sys_clk);
  endtask : pulse

  // cycles between two match pulses of channel 0, bounded
  task automatic meas(input logic b, output int n);
    int k;
    k = 0;
    while ((b ? match_b[0] : match_a[0]) !== 1'b1 && k < 100) begin
      @(negedge sys_clk);
      k++;
    end
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while ((b ? match_b[0] : match_a[0]) !== 1'b1 && n < 100);
  endtask : meas

  task automatic t_reset;
    logic [31:0] q;
    cpu.rd(ra(0, OFF_CNT), q);
    check("count reset", q, {16'h0000, RST_CNT});
    cpu.rd(ra(0, OFF_GRA), q);
    check("reg a reset", q, {16'h0000, RST_GR});
    cpu.rd(GLB_FUNC, q);
    check("comb reset", q, {30'h0, RST_CMB});
    cpu.rd(8'hFC, q);
    check("unmapped read", q, 32'h00000000);
    check("response okay", {31'h0, hresp}, 32'h00000000);
  endtask : t_reset

  task automatic t_period;
    int n;
    logic [31:0] q;
    cpu.wr(ra(0, OFF_GRA), 32'h00000004);
    cpu.wr(ra(0, OFF_GRB), 32'h00000006);
    cpu.wr(ra(0, OFF_CTRL), {30'h0, CLR_A});
    cpu.wr(GLB_RUN, 32'h00000001);
    meas(1'b0, n);
    check("period on a", n, 32'h00000005);
    // b above a so the count never has to wrap to reach it
    cpu.wr(ra(0, OFF_CTRL), {30'h0, CLR_B});
    meas(1'b1, n);
    check("period on b", n, 32'h00000007);
    // preset to 4 reaches 6 on the tick where the next preset lands,
    // so the clear must win; three more ticks until the stop lands
    cpu.wr(ra(0, OFF_CNT), 32'h00000004);
    cpu.wr(ra(0, OFF_CNT), 32'h00000100);
    cpu.wr(GLB_RUN, 32'h00000000);
    cpu.rd(ra(0, OFF_CNT), q);
    check("clear beats preset", q, 32'h00000003);
  endtask : t_period

  task automatic t_ovf;
    logic [31:0] q;
    cpu.wr(ra(1, OFF_CNT), 32'h0000FFF0);
    cpu.wr(GLB_RUN, 32'h00000002);
    repeat (30) @(posedge sys_clk);
    cpu.wr(GLB_RUN, 32'h00000000);
    // zero written before any read must not clear
    cpu.wr(ra(1, OFF_STAT), 32'h00000000);
    cpu.rd(ra(1, OFF_STAT), q);
    check("overflow set", {31'h0, q[ST_OVF]}, 32'h00000001);
    cpu.wr(ra(1, OFF_STAT), 32'h00000000);
    cpu.rd(ra(1, OFF_STAT), q);
    check("overflow cleared", {31'h0, q[ST_OVF]}, 32'h00000000);
    // second preset lands on the tick that leaves all-ones
    cpu.wr(GLB_RUN, 32'h00000002);
    cpu.wr(ra(1, OFF_CNT), 32'h0000FFFD);
    cpu.wr(ra(1, OFF_CNT), 32'h00000100);
    cpu.wr(GLB_RUN, 32'h00000000);
    cpu.rd(ra(1, OFF_CNT), q);
    check("preset beats step", q, 32'h00000103);
    cpu.rd(ra(1, OFF_STAT), q);
    check("overflow kept", {31'h0, q[ST_OVF]}, 32'h00000001);
  endtask : t_ovf

  task automatic t_capture;
    logic [31:0] q;
    cpu.wr(ra(2, OFF_CTRL), 32'h00000090);
    cpu.wr(ra(2, OFF_CNT), 32'h00001234);
    pulse(2, 1'b0);
    pulse(2, 1'b1);
    cpu.rd(ra(2, OFF_GRA), q);
    check("capture a", q, 32'h00001234);
    cpu.rd(ra(2, OFF_GRB), q);
    check("compare b untouched", q, 32'h0000FFFF);
    cpu.wr(ra(2, OFF_CNT), 32'h00002000);
    pulse(2, 1'b0);
    cpu.rd(ra(2, OFF_BRA), q);
    check("buffer gets old a", q, 32'h00001234);
    // delayed one edge, the access data phase meets the capture edge
    cpu.wr(ra(2, OFF_CNT), 32'h00003000);
    fork
      pulse(2, 1'b0);
      begin
        @(posedge sys_clk);
        cpu.wr(ra(2, OFF_BRA), 32'h00005555);
      end
    join
    cpu.rd(ra(2, OFF_BRA), q);
    check("buffer write dropped", q, 32'h00002000);
    cpu.wr(ra(2, OFF_CNT), 32'h00004000);
    fork
      pulse(2, 1'b0);
      begin
        @(posedge sys_clk);
        cpu.wr(ra(2, OFF_GRA), 32'h00005555);
      end
    join
    cpu.rd(ra(2, OFF_GRA), q);
    check("reg a write dropped", q, 32'h00004000);
    cpu.wr(ra(2, OFF_CNT), 32'h00005000);
    fork
      pulse(2, 1'b0);
      begin
        @(posedge sys_clk);
        cpu.rd(ra(2, OFF_GRA), q);
      end
    join
    check("read before capture", q, 32'h00004000);
    // pwm channel ignores its capture pin
    cpu.wr(ra(3, OFF_CTRL), 32'h00000050);
    cpu.wr(ra(3, OFF_CNT), 32'h00000777);
    pulse(3, 1'b0);
    cpu.rd(ra(3, OFF_GRA), q);
    check("no capture in pwm", q, 32'h0000FFFF);
    // running at full rate, the capture lands on the tick leaving all-ones
    cpu.wr(ra(2, OFF_CTRL), 32'h00000011);
    cpu.wr(GLB_RUN, 32'h00000004);
    cpu.wr(ra(2, OFF_CNT), 32'h0000FFFC);
    pulse(2, 1'b0);
    cpu.wr(GLB_RUN, 32'h00000000);
    cpu.rd(ra(2, OFF_GRA), q);
    check("pre-clear count", q, 32'h0000FFFF);
    // step skipped at the clear, then nine ticks until the stop lands
    cpu.rd(ra(2, OFF_CNT), q);
    check("capture clear", q, 32'h00000009);
    cpu.rd(ra(2, OFF_STAT), q);
    check("no overflow on clear", {31'h0, q[ST_OVF]}, 32'h00000000);
  endtask : t_capture

  task automatic t_sync;
    logic [31:0] q;
    cpu.wr(GLB_SYNC, 32'h00000003);
    cpu.wr(ra(0, OFF_CNT), 32'h000000AB);
    cpu.rd(ra(1, OFF_CNT), q);
    check("member preset", q, 32'h000000AB);
    cpu.rd(ra(3, OFF_CNT), q);
    check("non member kept", q, 32'h00000777);
    cpu.wr(GLB_SYNC, 32'h00000000);
  endtask : t_sync

  task automatic t_compl;
    logic [31:0] q, q2;
    cpu.wr(GLB_FUNC, {30'h0, CMB_COMPL});
    cpu.wr(ra(4, OFF_CNT), 32'h00000064);
    cpu.wr(GLB_RUN, 32'h00000018);
    repeat (20) @(posedge sys_clk);
    cpu.rd(ra(4, OFF_CNT), q);
    check("down count", {31'h0, q < 32'h00000064}, 32'h00000001);
    cpu.wr(GLB_FUNC, {30'h0, CMB_NORMAL});
    repeat (2) @(posedge sys_clk);
    cpu.wr(GLB_RUN, 32'h00000000);
    cpu.rd(ra(4, OFF_CNT), q);
    repeat (4) @(posedge sys_clk);
    cpu.rd(ra(4, OFF_CNT), q2);
    check("pair stopped", q2, q);
    cpu.wr(GLB_FUNC, {30'h0, CMB_RSYNC});
    cpu.wr(GLB_FUNC, {30'h0, CMB_NORMAL});
    cpu.rd(GLB_FUNC, q);
    check("back to normal", q, {30'h0, CMB_NORMAL});
  endtask : t_compl

  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_period;
    t_ovf;
    t_capture;
    t_sync;
    t_compl;
    report_and_stop;
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    errors++;
    report_and_stop;
  end
endmodule : tacl_tb
